// ==== verilog/dfsc_consts.vh ====
// constants for the spread-path codec configuration block
// assumes inclusion by the APB register file and its serializer
`ifndef DFSC_CONSTS_VH
`define DFSC_CONSTS_VH

////////////////////////////////////////////////////////////////
// register indices; byte address is four times the index
`define DFSC_IDX_ENC 6'h03
`define DFSC_IDX_SPARE 6'h04
`define DFSC_IDX_DEC 6'h05
`define DFSC_IDX_SF 6'h06
`define DFSC_IDX_SEED3 6'h07
`define DFSC_IDX_SEED2 6'h08
`define DFSC_IDX_SEED1 6'h09
`define DFSC_IDX_SEED0 6'h0A

////////////////////////////////////////////////////////////////
// reset values
`define DFSC_RST_ENC 8'h01
`define DFSC_RST_SPARE 8'h00
`define DFSC_RST_DEC 8'h01
`define DFSC_RST_SF 8'h22
`define DFSC_RST_SEED3 8'h01
`define DFSC_RST_SEED2 8'h6E
`define DFSC_RST_SEED1 8'hCD
`define DFSC_RST_SEED0 8'h5F

////////////////////////////////////////////////////////////////
// field positions
`define DFSC_ENC_INTLV_ON 0
`define DFSC_ENC_START 1
`define DFSC_ENC_BYTE 2
`define DFSC_ENC_BIT 3
`define DFSC_ENC_INTLV_ORD 4
`define DFSC_ENC_W 5
`define DFSC_DEC_DEINTLV_ON 0
`define DFSC_DEC_TERM 1
`define DFSC_DEC_OUT_ORD 2
`define DFSC_DEC_IN_ORD 3
`define DFSC_DEC_DEINTLV_ORD 4
`define DFSC_DEC_CRC_SPAN 5
`define DFSC_DEC_W 6
`define DFSC_SF_HDR_LO 0
`define DFSC_SF_PAY_LO 4

////////////////////////////////////////////////////////////////
// spreading factor codes and chip counts
`define DFSC_SF_CODE_16 2'h0
`define DFSC_SF_CODE_32 2'h1
`define DFSC_SF_CODE_64 2'h2
`define DFSC_SF_CODE_8 2'h3
`define DFSC_CHIPS_16 7'h10
`define DFSC_CHIPS_32 7'h20
`define DFSC_CHIPS_64 7'h40
`define DFSC_CHIPS_8 7'h08

////////////////////////////////////////////////////////////////
// convolutional code taps, constraint length seven
`define DFSC_POLY_A 7'h5B
`define DFSC_POLY_B 7'h79
`define DFSC_ZERO_BYTE 8'h00

`endif

// ==== verilog/dfsc_bit_serial.v ====
// byte to bit serializer feeding the error-correction encoder
// assumes one clock, loads a byte when ld_ready is high
`include "dfsc_consts.vh"

module dfsc_bit_serial (
  input wire pclk,
  input wire presetn,
  input wire msb_first,
  input wire [7:0] ld_data,
  input wire ld_last,
  input wire ld_valid,
  output reg ld_ready,
  output wire bit_out,
  output wire bit_last,
  output wire bit_valid,
  input wire bit_ready
);

  reg [7:0] shreg;
  reg [2:0] left;
  reg busy;
  reg last_byte;
  wire take_bit;
  wire take_byte;

  ////////////////////////////////////////////////////////////////
  // first bit of the byte always leaves from bit 7 of shreg
  assign bit_out = shreg[7];
  assign bit_valid = busy;
  assign take_bit = busy & bit_ready;
  assign take_byte = ld_valid & ld_ready;
  assign bit_last = last_byte & (left == 3'h0);

  // shift state; order chosen when the byte is loaded
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg <= 8'h00;
      left <= 3'h0;
      busy <= 1'b0;
      last_byte <= 1'b0;
      ld_ready <= 1'b1;
    end else if (take_byte) begin
      shreg <= msb_first ? ld_data :
        {ld_data[0], ld_data[1], ld_data[2], ld_data[3],
         ld_data[4], ld_data[5], ld_data[6], ld_data[7]};
      left <= 3'h7;
      busy <= 1'b1;
      last_byte <= ld_last;
      ld_ready <= 1'b0;
    end else if (take_bit) begin
      shreg <= {shreg[6:0], 1'b0};
      left <= left - 3'h1;
      busy <= (left != 3'h0);
      ld_ready <= (left == 3'h0); // byte gap of one cycle, keeps ready a flop
    end
  end

endmodule

// ==== verilog/dfsc_codec_cfg.v ====
// spread-path codec configuration: APB register file, transmit
// encoder feed, receive reordering and spreading factor decode
// assumes APB master on pclk; stream partners honour valid/ready
//
// The APB slave port was left to the implementer.
`include "dfsc_consts.vh"

module dfsc_codec_cfg #(
  parameter AW = 8,
  parameter LW = 11
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] tx_data,
  input wire tx_last,
  input wire tx_valid,
  output reg tx_ready,
  output reg [1:0] coded_bits,
  output reg coded_last,
  output reg coded_valid,
  input wire coded_ready,
  input wire [7:0] deint_data,
  input wire deint_valid,
  output reg [7:0] deint_out,
  output reg deint_out_valid,
  input wire [7:0] dec_data,
  input wire dec_valid,
  output reg [7:0] dec_out,
  output reg dec_out_valid,
  input wire [LW-1:0] rx_length,
  input wire [2:0] crc_length,
  output reg [LW-1:0] crc_span_end,
  output reg interleave_byte_order,
  output reg interleaver_on,
  output reg deinterleaver_on,
  output reg decoder_input_bit_order,
  output reg decoder_termination_select,
  output reg [6:0] payload_chips,
  output reg [6:0] header_chips,
  output reg [24:0] header_gold_seed
);

  ////////////////////////////////////////////////////////////////
  // register storage; only implemented bits exist
  reg [`DFSC_ENC_W-1:0] enc_ctrl;
  reg [`DFSC_DEC_W-1:0] dec_ctrl;
  reg [7:0] spare;
  reg [1:0] payload_spread_factor;
  reg [1:0] header_spread_factor;
  reg [24:0] seed;
  reg [7:0] next_rdata;
  reg next_err;
  wire [5:0] idx;
  wire wr_en;
  wire setup;

  // full-byte reset words, sliced to the implemented fields below
  localparam [7:0] ENC_RST = `DFSC_RST_ENC;
  localparam [7:0] DEC_RST = `DFSC_RST_DEC;
  localparam [7:0] SF_RST = `DFSC_RST_SF;
  localparam [31:0] SEED_RST = {`DFSC_RST_SEED3, `DFSC_RST_SEED2, `DFSC_RST_SEED1, `DFSC_RST_SEED0};

  assign idx = paddr[7:2];
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;

  function [7:0] rev8;
    input [7:0] d;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1)
        rev8[i] = d[7-i];
    end
  endfunction

  function [6:0] chips;
    input [1:0] code;
    begin
      case (code)
        `DFSC_SF_CODE_16: chips = `DFSC_CHIPS_16;
        `DFSC_SF_CODE_32: chips = `DFSC_CHIPS_32;
        `DFSC_SF_CODE_64: chips = `DFSC_CHIPS_64;
        default: chips = `DFSC_CHIPS_8;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // read mux; reserved bits read zero
  always @* begin
    next_rdata = 8'h00;
    next_err = 1'b0;
    case (idx)
      `DFSC_IDX_ENC: next_rdata = {3'h0, enc_ctrl};
      `DFSC_IDX_SPARE: next_rdata = spare;
      `DFSC_IDX_DEC: next_rdata = {2'h0, dec_ctrl};
      `DFSC_IDX_SF: next_rdata = {2'h0, payload_spread_factor,
        2'h0, header_spread_factor};
      `DFSC_IDX_SEED3: next_rdata = {7'h00, seed[24]};
      `DFSC_IDX_SEED2: next_rdata = seed[23:16];
      `DFSC_IDX_SEED1: next_rdata = seed[15:8];
      `DFSC_IDX_SEED0: next_rdata = seed[7:0];
      default: next_err = 1'b1;
    endcase
  end

  // apb answer: pready rises in the first access cycle, no waits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? 32'h00000000 : {24'h000000, next_rdata};
        pslverr <= next_err;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // register writes; upper bits of write data are dropped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_ctrl <= ENC_RST[`DFSC_ENC_W-1:0];
      dec_ctrl <= DEC_RST[`DFSC_DEC_W-1:0];
      spare <= `DFSC_RST_SPARE;
      payload_spread_factor <= SF_RST[`DFSC_SF_PAY_LO+1:`DFSC_SF_PAY_LO];
      header_spread_factor <= SF_RST[`DFSC_SF_HDR_LO+1:`DFSC_SF_HDR_LO];
      seed <= SEED_RST[24:0];
    end else if (wr_en) begin
      case (idx)
        `DFSC_IDX_ENC: enc_ctrl <= pwdata[`DFSC_ENC_W-1:0];
        `DFSC_IDX_SPARE: spare <= pwdata[7:0];
        `DFSC_IDX_DEC: dec_ctrl <= pwdata[`DFSC_DEC_W-1:0];
        `DFSC_IDX_SF: begin
          payload_spread_factor <= pwdata[`DFSC_SF_PAY_LO+1:`DFSC_SF_PAY_LO];
          header_spread_factor <= pwdata[`DFSC_SF_HDR_LO+1:`DFSC_SF_HDR_LO];
        end
        `DFSC_IDX_SEED3: seed[24] <= pwdata[0];
        `DFSC_IDX_SEED2: seed[23:16] <= pwdata[7:0];
        `DFSC_IDX_SEED1: seed[15:8] <= pwdata[7:0];
        `DFSC_IDX_SEED0: seed[7:0] <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // configuration levels leave through flops, one cycle behind
  // the registers; arbitrary length with enables set is not
  // blocked here, software owns that combination
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interleave_byte_order <= 1'b0;
      interleaver_on <= 1'b1;
      deinterleaver_on <= 1'b1;
      decoder_input_bit_order <= 1'b0;
      decoder_termination_select <= 1'b0;
      payload_chips <= `DFSC_CHIPS_64;
      header_chips <= `DFSC_CHIPS_64;
      header_gold_seed <= 25'h0000000;
    end else begin
      interleave_byte_order <= enc_ctrl[`DFSC_ENC_INTLV_ORD];
      interleaver_on <= enc_ctrl[`DFSC_ENC_INTLV_ON];
      deinterleaver_on <= dec_ctrl[`DFSC_DEC_DEINTLV_ON];
      decoder_input_bit_order <= dec_ctrl[`DFSC_DEC_IN_ORD];
      decoder_termination_select <= dec_ctrl[`DFSC_DEC_TERM];
      payload_chips <= chips(payload_spread_factor);
      header_chips <= chips(header_spread_factor);
      header_gold_seed <= seed;
    end
  end

  ////////////////////////////////////////////////////////////////
  // transmit feed: last byte zeroed when encoder starts from zero
  wire start_zero;
  wire [7:0] feed_data;
  wire ser_ready;
  wire bit_in;
  wire bit_last;
  wire bit_valid;
  wire bit_ready;
  wire feed_take;

  assign start_zero = ~enc_ctrl[`DFSC_ENC_START];
  assign feed_data = (tx_last & start_zero) ? `DFSC_ZERO_BYTE : tx_data;
  // a byte moves only while tx_ready is shown, so the source sees every take
  assign feed_take = tx_valid & tx_ready;

  dfsc_bit_serial u_ser (
    .pclk(pclk),
    .presetn(presetn),
    .msb_first(enc_ctrl[`DFSC_ENC_BIT]),
    .ld_data(feed_data),
    .ld_last(tx_last),
    .ld_valid(feed_take),
    .ld_ready(ser_ready),
    .bit_out(bit_in),
    .bit_last(bit_last),
    .bit_valid(bit_valid),
    .bit_ready(bit_ready)
  );

  // tx_ready mirrors the serializer one cycle late, so a byte is
  // only counted when both agree; the gap costs a cycle per byte
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tx_ready <= 1'b0;
    else
      tx_ready <= ser_ready & ~feed_take;
  end

  ////////////////////////////////////////////////////////////////
  // rate one-half convolutional encoder with an output slot
  reg [5:0] enc_state;
  wire [6:0] taps;
  wire par_a;
  wire par_b;
  wire bit_take;

  assign bit_ready = ~coded_valid | coded_ready;
  assign bit_take = bit_valid & bit_ready;
  assign taps = {bit_in, enc_state};
  assign par_a = ^(taps & `DFSC_POLY_A);
  assign par_b = ^(taps & `DFSC_POLY_B);

  // state clears at frame end only in zero-start mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_state <= 6'h00;
      coded_bits <= 2'h0;
      coded_last <= 1'b0;
      coded_valid <= 1'b0;
    end else begin
      if (bit_take) begin
        if (bit_last & start_zero)
          enc_state <= 6'h00;
        else
          enc_state <= {bit_in, enc_state[5:1]};
        coded_bits <= enc_ctrl[`DFSC_ENC_BYTE] ? {par_a, par_b} : {par_b, par_a};
        coded_last <= bit_last;
        coded_valid <= 1'b1;
      end else if (coded_ready) begin
        coded_valid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // receive reordering; bit 7 of each output goes first
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deint_out <= 8'h00;
      deint_out_valid <= 1'b0;
      dec_out <= 8'h00;
      dec_out_valid <= 1'b0;
    end else begin
      deint_out_valid <= deint_valid;
      if (deint_valid)
        deint_out <= dec_ctrl[`DFSC_DEC_DEINTLV_ORD] ? rev8(deint_data) : deint_data;
      dec_out_valid <= dec_valid;
      if (dec_valid)
        dec_out <= dec_ctrl[`DFSC_DEC_OUT_ORD] ? dec_data : rev8(dec_data);
    end
  end

  ////////////////////////////////////////////////////////////////
  // crc span end index; both forms drop one byte, the narrower form also drops crc_length more
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      crc_span_end <= {LW{1'b0}};
    else if (dec_ctrl[`DFSC_DEC_CRC_SPAN])
      crc_span_end <= rx_length - {{(LW-1){1'b0}}, 1'b1}
        - {{(LW-3){1'b0}}, crc_length};
    else
      crc_span_end <= rx_length - {{(LW-1){1'b0}}, 1'b1};
  end

endmodule

// ==== sim/dfsc_codec_cfg_properties.sv ====
// port assertions for the spread-path codec configuration block
// assumes a bind into dfsc_codec_cfg, one pclk domain
module dfsc_codec_cfg_checker #(
  parameter AW = 8,
  parameter LW = 11
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire [1:0] coded_bits,
  input wire coded_valid,
  input wire coded_ready,
  input wire deint_valid,
  input wire deint_out_valid,
  input wire [LW-1:0] rx_length,
  input wire [2:0] crc_length,
  input wire [LW-1:0] crc_span_end,
  input wire decoder_termination_select,
  input wire [6:0] payload_chips,
  input wire [24:0] header_gold_seed
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////
  // helpers; span_b may wrap, as the design's subtraction does
  wire wr = psel && penable && pready && pwrite;
  wire [5:0] idx = paddr[7:2];
  wire [LW-1:0] span_a = rx_length - 1'b1;
  wire [LW-1:0] span_b = span_a - crc_length;
  function automatic [6:0] chips(input [1:0] c);
    chips = c == 2'h0 ? 7'h10 : c == 2'h1 ? 7'h20 : c == 2'h2 ? 7'h40 : 7'h08;
  endfunction
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  a_ready_setup: assert property (psel && !penable |=> pready) else $error("no answer");
  a_ready_pulse: assert property (pready |=> !pready) else $error("long answer");
  a_err_unmapped: assert property (pready |-> pslverr == (idx < 6'h03 || idx > 6'h0A))
    else $error("bad error flag");
  a_pay_chips: assert property (wr && idx == 6'h06 |-> ##2 payload_chips == chips($past(pwdata[5:4], 2)))
    else $error("bad chips");
  a_seed_mid: assert property (wr && idx == 6'h08 |-> ##2 header_gold_seed[23:16] == $past(pwdata[7:0], 2))
    else $error("bad seed");
  a_term_copy: assert property (wr && idx == 6'h05 |-> ##2 decoder_termination_select == $past(pwdata[1], 2))
    else $error("bad term");
  a_crc_span: assert property (1'b1 |=> crc_span_end == $past(span_a) || crc_span_end == $past(span_b))
    else $error("bad span");
  a_coded_hold: assert property (coded_valid && !coded_ready |=> coded_valid && $stable(coded_bits))
    else $error("pair dropped");
  a_deint_pulse: assert property (deint_valid |=> deint_out_valid) else $error("no output");
  c_sf_write: cover property (wr && idx == 6'h06);
  c_unmapped: cover property (pready && pslverr);
  c_stall: cover property (coded_valid && !coded_ready);
endmodule

bind dfsc_codec_cfg dfsc_codec_cfg_checker #(.AW(AW), .LW(LW)) i_dfsc_codec_cfg_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .coded_bits(coded_bits), .coded_valid(coded_valid),
  .coded_ready(coded_ready), .deint_valid(deint_valid), .deint_out_valid(deint_out_valid),
  .rx_length(rx_length), .crc_length(crc_length), .crc_span_end(crc_span_end),
  .decoder_termination_select(decoder_termination_select), .payload_chips(payload_chips),
  .header_gold_seed(header_gold_seed));

// ==== sim/dfsc_link_peer.sv ====
// far-end model taking coded pairs off the encoder
// assumes pclk domain; slow makes it stall at random
module dfsc_link_peer (
  input wire pclk,
  input wire presetn,
  input wire slow,
  output logic coded_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // prompt, or ready one cycle in three to exercise the hold path
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      coded_ready <= 1'b0;
    else
      coded_ready <= !slow || ($urandom % 3 == 0);
  end
endmodule

// ==== sim/dfsc_codec_cfg_bench.sv ====
// self-checking bench for the codec configuration block
// assumes design, checker with its bind, and link peer compiled first
module dfsc_codec_cfg_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, tx_last, tx_valid, tx_ready;
  logic coded_last, coded_valid, coded_ready, deint_valid, dec_valid, deint_out_valid, dec_out_valid;
  logic interleave_byte_order, interleaver_on, deinterleaver_on, dec_in_ord, dec_term;
  logic [7:0] paddr, tx_data, deint_data, dec_data, deint_out, dec_out, v, a, b;
  logic [31:0] pwdata, prdata;
  logic [1:0] coded_bits;
  logic [10:0] rx_length, crc_span_end;
  logic [2:0] crc_length;
  logic [6:0] payload_chips, header_chips;
  logic [24:0] header_gold_seed;
  logic [7:0] wv [3:10];
  logic [7:0] rst_v [3:10] = '{8'h01, 8'h00, 8'h01, 8'h22, 8'h01, 8'h6E, 8'hCD, 8'h5F};
  logic [7:0] msk [3:10] = '{8'h1F, 8'hFF, 8'h3F, 8'h33, 8'h01, 8'hFF, 8'hFF, 8'hFF};
  logic [6:0] chips [4] = '{7'h10, 7'h20, 7'h40, 7'h08};
  logic [32:0] q_rd [$];
  logic [7:0] q_dt [$], q_dc [$];
  logic [3:0] q_pr [$];
  int n_errors = 0, compares = 0;
  ////////////////////////////////////////
  dfsc_codec_cfg #(.AW(8), .LW(11)) i_dfsc_codec_cfg (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_data(tx_data),
    .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready), .coded_bits(coded_bits),
    .coded_last(coded_last), .coded_valid(coded_valid), .coded_ready(coded_ready),
    .deint_data(deint_data), .deint_valid(deint_valid), .deint_out(deint_out),
    .deint_out_valid(deint_out_valid), .dec_data(dec_data), .dec_valid(dec_valid), .dec_out(dec_out),
    .dec_out_valid(dec_out_valid), .rx_length(rx_length), .crc_length(crc_length),
    .crc_span_end(crc_span_end), .interleave_byte_order(interleave_byte_order),
    .interleaver_on(interleaver_on), .deinterleaver_on(deinterleaver_on),
    .decoder_input_bit_order(dec_in_ord), .decoder_termination_select(dec_term),
    .payload_chips(payload_chips), .header_chips(header_chips), .header_gold_seed(header_gold_seed));
  dfsc_link_peer i_dfsc_link_peer (.pclk(pclk), .presetn(presetn), .slow(slow), .coded_ready(coded_ready));
  ////////////////////////////////////////
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task end_of_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // bounded wait for pready or tx_ready; a hang ends the run
  task wt(input logic tx);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((tx ? tx_ready : pready) !== 1'b1 && n < 200);
    if ((tx ? tx_ready : pready) !== 1'b1) begin
      n_errors++;
      end_of_test;
    end
  endtask
  task apb(input logic w, input logic [5:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= ($urandom << 8) | d;
    @(posedge pclk);
    penable <= 1'b1;
    wt(1'b0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [5:0] i, input logic [7:0] e, input logic err);
    q_rd.push_back({err, 24'h0, e});
    apb(1'b0, i, 8'h00);
  endtask
  task send(input logic [7:0] d, input logic last);
    @(posedge pclk);
    tx_data <= d;
    tx_last <= last;
    tx_valid <= 1'b1;
    wt(1'b1);
    tx_valid <= 1'b0;
  endtask
  // only the first pair of a frame is predictable unless all are zero
  task pairs(input int nb, input logic full, input logic [1:0] f);
    for (int k = 0; k < 8 * nb; k++)
      q_pr.push_back({full || k == 0, k == 8 * nb - 1, k == 0 ? f : 2'h0});
  endtask
  // bounded wait until every noted pair has been seen
  task drain;
    int k;
    k = 0;
    while (q_pr.size() != 0 && k < 400) begin
      @(posedge pclk);
      k++;
    end
    if (q_pr.size() != 0) begin
      n_errors++;
      end_of_test;
    end
  endtask
  function automatic logic [7:0] rev8(input logic [7:0] x);
    for (int k = 0; k < 8; k++)
      rev8[k] = x[7 - k];
  endfunction
  ////////////////////////////////////////
  // compare each result with the oldest note of its kind
  always @(posedge pclk) begin
    logic [32:0] e;
    logic [3:0] p;
    if (psel && penable && pready && !pwrite) begin
      e = q_rd.size() ? q_rd.pop_front() : 'x;
      chk("prdata", e[31:0], prdata);
      chk("pslverr", e[32], pslverr);
    end
    if (coded_valid && coded_ready) begin
      p = q_pr.size() ? q_pr.pop_front() : 'x;
      chk("coded_last", p[2], coded_last);
      if (p[3] !== 1'b0)
        chk("coded_bits", p[1:0], coded_bits);
    end
    if (deint_out_valid)
      chk("deint_out", q_dt.size() ? q_dt.pop_front() : 'x, deint_out);
    if (dec_out_valid)
      chk("dec_out", q_dc.size() ? q_dc.pop_front() : 'x, dec_out);
  end
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // reset, registers, spreading codes, receive reorder, transmit frames
  initial begin
    {psel, penable, pwrite, paddr, pwdata, slow, tx_data, tx_last, tx_valid} = '0;
    {deint_data, deint_valid, dec_data, dec_valid, rx_length, crc_length} = '0;
    presetn = 1'b0;
    void'($urandom(64354));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 3; i <= 10; i++)
      rd(6'(i), rst_v[i], 1'b0);
    rd(6'h0B, 8'h00, 1'b1);
    chk("header_gold_seed", 25'h16ECD5F, header_gold_seed);
    chk("interleaver_on", 1'b1, interleaver_on);
    for (int i = 3; i <= 10; i++) begin
      wv[i] = 8'($urandom);
      apb(1'b1, 6'(i), wv[i]);
      rd(6'(i), wv[i] & msk[i], 1'b0);
    end
    apb(1'b1, 6'h0B, 8'hFF);
    rd(6'h0B, 8'h00, 1'b1);
    chk("header_gold_seed", {wv[7][0], wv[8], wv[9], wv[10]}, header_gold_seed);
    chk("interleave_byte_order", wv[3][4], interleave_byte_order);
    chk("decoder_termination_select", wv[5][1], dec_term);
    // payload factor 8 comes last, after the wider factors; header factors run in reverse
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 6'h06, {2'h0, 2'(c), 2'h0, 2'(3 - c)});
      repeat (2) @(posedge pclk);
      chk("payload_chips", chips[c], payload_chips);
      chk("header_chips", chips[3 - c], header_chips);
    end
    for (int r = 0; r < 6; r++) begin
      v = 8'($urandom) & 8'h3F;
      apb(1'b1, 6'h05, v);
      a = 8'($urandom);
      b = 8'($urandom);
      @(posedge pclk);
      {deint_data, dec_data, deint_valid, dec_valid} <= {a, b, 2'h3};
      {rx_length, crc_length} <= 14'($urandom);
      q_dt.push_back(v[4] ? rev8(a) : a);
      q_dc.push_back(v[2] ? b : rev8(b));
      @(posedge pclk);
      {deint_valid, dec_valid} <= 2'h0;
      repeat (2) @(posedge pclk);
      chk("crc_span_end", 11'(rx_length - 11'h1 - (v[5] ? crc_length : 3'h0)), crc_span_end);
      chk("decoder_input_bit_order", v[3], dec_in_ord);
      chk("deinterleaver_on", v[0], deinterleaver_on);
    end
    slow <= 1'b1;
    apb(1'b1, 6'h03, 8'h00);
    pairs(2, 1'b0, 2'h3);
    send(8'h01, 1'b0);
    send(8'hFF, 1'b1);
    drain;
    pairs(1, 1'b1, 2'h0);
    send(8'hFF, 1'b1);
    drain;
    apb(1'b1, 6'h03, 8'h0A);
    pairs(1, 1'b0, 2'h3);
    send(8'h80, 1'b1);
    drain;
    chk("pairs left", 0, q_pr.size());
    end_of_test;
  end
endmodule
